//--- core/lfp_pkg.sv
// Package: register map, field positions and constants of the LED fault and protection block
package lfp_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] THRESH_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
  localparam logic [7:0] OPEN_CH_LO_OFS = 8'h14;
  localparam logic [7:0] OPEN_CH_HI_OFS = 8'h18;
  localparam logic [7:0] SHORT_CH_LO_OFS = 8'h1C;
  localparam logic [7:0] SHORT_CH_HI_OFS = 8'h20;
  localparam logic [7:0] OPEN_LINE_LO_OFS = 8'h24;
  localparam logic [7:0] OPEN_LINE_HI_OFS = 8'h28;
  localparam logic [7:0] SHORT_LINE_LO_OFS = 8'h2C;
  localparam logic [7:0] SHORT_LINE_HI_OFS = 8'h30;
  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_GHOST_EN_BIT = 0;
  localparam int CTRL_READBACK_BIT = 1;
  localparam int CTRL_SHORT_RM_LSB = 2;
  localparam int SHORT_RM_W = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int THRESH_W = 24;
  localparam logic [23:0] THRESH_RESET = 24'h000000;
  // ----------------------------------------------------------------
  // Interrupt event bit positions
  // ----------------------------------------------------------------
  localparam int IRQ_W = 5;
  localparam int EV_OPEN = 0;
  localparam int EV_SHORT = 1;
  localparam int EV_REF_SHORT = 2;
  localparam int EV_THERMAL = 3;
  localparam int EV_POWER_SAVE = 4;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CHANNELS = 48;
  localparam int LINES = 64;
  localparam int LINE_W = 6;
  localparam int GHOST_SLOTS = 3;
  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Reported device mode, highest priority first
  typedef enum logic [2:0] {
    LFP_MODE_INIT = 3'h0,
    LFP_MODE_THERMAL = 3'h1,
    LFP_MODE_REF_SHORT = 3'h2,
    LFP_MODE_POWER_SAVE = 3'h3,
    LFP_MODE_NORMAL = 3'h4
  } lfp_mode_e;
endpackage

//--- core/lfp_fault_protect.sv
// LED fault detection, open-ghost removal and protection modes with an AXI4-Lite register slave
//
// How it works
// - Reference-short comparator low forces all channels off until it reports high.
// - Open bit per channel is one when output exceeds its colour's open threshold.
// - Open comparator result counts only while that channel is switched on.
// - Segment end latches 48 open bits and logs the scan line holding faults.
// - With removal enabled, faulted channel is off on its open line until cleared.
// - Removal covers only the first three lines with open faults.
// - Short bit per channel is one when output is below its short threshold.
// - Short comparator result counts only while that channel is switched on.
// - Segment end latches 48 short bits and logs the scan line holding faults.
// - Undervoltage enters initialization and resets every register.
// - All-zero next frame enters power saving at frame sync, channels off.
// - Any non-zero next-frame data leaves power saving at once.
// - Thermal shutdown above 170 C forces channels off, resumes below 155 C.
`timescale 1ns/1ps
module lfp_fault_protect (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog comparators, asynchronous
  input wire logic [47:0] open_cmp,
  input wire logic [47:0] short_cmp,
  input wire logic ref_below_low,
  input wire logic ref_above_high,
  input wire logic temp_above_hot,
  input wire logic temp_below_cool,
  input wire logic supply_undervoltage,
  // Scan and display engine, same clock
  input wire logic [47:0] channel_on,
  input wire logic [5:0] scan_line,
  input wire logic segment_end,
  input wire logic frame_sync,
  input wire logic next_frame_all_zero,
  input wire logic next_frame_nonzero,
  // Outputs
  output logic [47:0] channel_output,
  output logic [23:0] threshold_codes,
  output logic [1:0] short_ghost_removal_setting,
  output logic irq
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [100:0] sync_a;
  logic [100:0] sync_b;
  logic [47:0] open_s;
  logic [47:0] short_s;
  logic ref_low_s, ref_high_s, hot_s, cool_s, uvlo_s;
  logic [95:0] on_pipe; // Lit mask aged two cycles so it lines up with the synced comparators
  // Comparators are asynchronous to aclk; only sync_b is read by logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= '0;
      sync_b <= '0;
      on_pipe <= '0;
    end else begin
      on_pipe <= {on_pipe[47:0], channel_on};
      sync_a <= {supply_undervoltage, temp_below_cool, temp_above_hot, ref_above_high,
                 ref_below_low, short_cmp, open_cmp};
      sync_b <= sync_a;
    end
  end
  assign open_s = sync_b[47:0];
  assign short_s = sync_b[95:48];
  assign ref_low_s = sync_b[96];
  assign ref_high_s = sync_b[97];
  assign hot_s = sync_b[98];
  assign cool_s = sync_b[99];
  assign uvlo_s = sync_b[100];

  // Initialization state clears everything except the bus handshake and the input synchronisers
  logic rst_regs;
  assign rst_regs = !aresetn || uvlo_s;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [3:0] ctrl;
  logic [23:0] thresh;
  logic [4:0] irq_status;
  logic [4:0] irq_mask;
  logic [47:0] open_acc, short_acc, open_chan, short_chan;
  logic [63:0] open_line_log, short_line_log;
  logic ref_short, thermal, power_save, ps_pending;
  logic [4:0] events;
  logic ghost_en;
  assign ghost_en = ctrl[lfp_pkg::CTRL_GHOST_EN_BIT];

  // Bus write strobes, defined with the slave below
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;

  // Control and threshold registers; thresholds drive the analog comparators
  always_ff @(posedge aclk) begin
    if (rst_regs) begin
      ctrl <= lfp_pkg::CTRL_RESET;
      thresh <= lfp_pkg::THRESH_RESET;
      irq_mask <= '0;
    end else if (wr_fire) begin
      if (wr_addr == lfp_pkg::CTRL_OFS) ctrl <= wr_data[3:0];
      if (wr_addr == lfp_pkg::THRESH_OFS) thresh <= wr_data[23:0];
      if (wr_addr == lfp_pkg::IRQ_MASK_OFS) irq_mask <= wr_data[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Fault detection per segment
  // ----------------------------------------------------------------
  // Comparator results only count while the channel conducts
  always_ff @(posedge aclk) begin
    if (rst_regs || segment_end) begin
      open_acc <= '0;
      short_acc <= '0;
    end else begin
      open_acc <= open_acc | (open_s & channel_on & on_pipe[95:48]);
      short_acc <= short_acc | (short_s & channel_on & on_pipe[95:48]);
    end
  end

  // Segment end: latch channel bits, fresh each segment, and log the line
  always_ff @(posedge aclk) begin
    if (rst_regs) begin
      open_chan <= '0;
      short_chan <= '0;
      open_line_log <= '0;
      short_line_log <= '0;
    end else if (segment_end) begin
      open_chan <= open_acc;
      short_chan <= short_acc;
      if (|open_acc) open_line_log[scan_line] <= 1'b1;
      if (|short_acc) short_line_log[scan_line] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Open-ghost removal slots
  // ----------------------------------------------------------------
  logic [2:0] slot_valid;
  logic [5:0] slot_line [3];
  logic [47:0] slot_mask [3];
  logic [2:0] slot_hit_seg;
  logic [47:0] ghost_off;
  logic [47:0] slot_off [3];

  // Per-slot match against the current scan line
  genvar g;
  generate
    for (g = 0; g < lfp_pkg::GHOST_SLOTS; g++) begin : g_slot
      assign slot_hit_seg[g] = slot_valid[g] && (slot_line[g] == scan_line);
      assign slot_off[g] = (ghost_en && slot_hit_seg[g]) ? slot_mask[g] : '0;
    end
  endgenerate
  assign ghost_off = slot_off[0] | slot_off[1] | slot_off[2];

  // Slots fill in detection order; a fourth line finds no slot and is left alone
  always_ff @(posedge aclk) begin
    if (rst_regs || !ghost_en) begin
      slot_valid <= '0;
      for (int i = 0; i < lfp_pkg::GHOST_SLOTS; i++) begin
        slot_line[i] <= '0;
        slot_mask[i] <= '0;
      end
    end else if (segment_end && |open_acc) begin
      if (|slot_hit_seg) begin
        for (int i = 0; i < lfp_pkg::GHOST_SLOTS; i++) begin
          if (slot_hit_seg[i]) slot_mask[i] <= slot_mask[i] | open_acc;
        end
      end else if (!slot_valid[0]) begin
        slot_valid[0] <= 1'b1;
        slot_line[0] <= scan_line;
        slot_mask[0] <= open_acc;
      end else if (!slot_valid[1]) begin
        slot_valid[1] <= 1'b1;
        slot_line[1] <= scan_line;
        slot_mask[1] <= open_acc;
      end else if (!slot_valid[2]) begin
        slot_valid[2] <= 1'b1;
        slot_line[2] <= scan_line;
        slot_mask[2] <= open_acc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Protection modes
  // ----------------------------------------------------------------
  // Hysteresis: entry and exit come from separate comparators
  always_ff @(posedge aclk) begin
    if (rst_regs) begin
      ref_short <= 1'b0;
      thermal <= 1'b0;
    end else begin
      if (ref_low_s) ref_short <= 1'b1;
      else if (ref_high_s) ref_short <= 1'b0;
      if (hot_s) thermal <= 1'b1;
      else if (cool_s) thermal <= 1'b0;
    end
  end

  // Power saving: armed by an all-zero frame, taken at frame sync, left at once
  always_ff @(posedge aclk) begin
    if (rst_regs) begin
      ps_pending <= 1'b0;
      power_save <= 1'b0;
    end else if (next_frame_nonzero) begin
      ps_pending <= 1'b0;
      power_save <= 1'b0;
    end else begin
      if (next_frame_all_zero) ps_pending <= 1'b1;
      if (frame_sync && (ps_pending || next_frame_all_zero)) begin
        power_save <= 1'b1;
        ps_pending <= 1'b0;
      end
    end
  end

  // Reported mode, highest priority first
  lfp_pkg::lfp_mode_e mode;
  always_comb begin
    case ({uvlo_s, thermal, ref_short, power_save})
      4'b0000: mode = lfp_pkg::LFP_MODE_NORMAL;
      4'b0001: mode = lfp_pkg::LFP_MODE_POWER_SAVE;
      4'b0010, 4'b0011: mode = lfp_pkg::LFP_MODE_REF_SHORT;
      default: mode = uvlo_s ? lfp_pkg::LFP_MODE_INIT : lfp_pkg::LFP_MODE_THERMAL;
    endcase
  end

  // Any single off request wins over the display engine
  always_ff @(posedge aclk) begin
    if (rst_regs) begin
      channel_output <= '0;
    end else if (ref_short || thermal || power_save) begin
      channel_output <= '0;
    end else begin
      channel_output <= channel_on & ~ghost_off;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic ref_short_d, thermal_d, power_save_d;
  always_ff @(posedge aclk) begin
    if (rst_regs) begin
      ref_short_d <= 1'b0;
      thermal_d <= 1'b0;
      power_save_d <= 1'b0;
    end else begin
      ref_short_d <= ref_short;
      thermal_d <= thermal;
      power_save_d <= power_save;
    end
  end
  assign events = {power_save & ~power_save_d, thermal & ~thermal_d,
                   ref_short & ~ref_short_d, segment_end & |short_acc,
                   segment_end & |open_acc};

  // Write one to clear; a new event in the clearing cycle is kept
  always_ff @(posedge aclk) begin
    if (rst_regs) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_fire && wr_addr == lfp_pkg::IRQ_STATUS_OFS) begin
        irq_status <= (irq_status & ~wr_data[4:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Fault words read as zero until readback is enabled
  function automatic logic [32:0] read_reg(input logic [7:0] a);
    logic rb;
    rb = ctrl[lfp_pkg::CTRL_READBACK_BIT];
    case (a)
      lfp_pkg::CTRL_OFS: read_reg = {1'b1, 28'h0, ctrl};
      lfp_pkg::THRESH_OFS: read_reg = {1'b1, 8'h0, thresh};
      lfp_pkg::STATUS_OFS: read_reg = {1'b1, 25'h0, mode, uvlo_s, thermal, ref_short,
                                       power_save};
      lfp_pkg::IRQ_STATUS_OFS: read_reg = {1'b1, 27'h0, irq_status};
      lfp_pkg::IRQ_MASK_OFS: read_reg = {1'b1, 27'h0, irq_mask};
      lfp_pkg::OPEN_CH_LO_OFS: read_reg = {1'b1, rb ? open_chan[31:0] : 32'h0};
      lfp_pkg::OPEN_CH_HI_OFS: read_reg = {1'b1, 16'h0, rb ? open_chan[47:32] : 16'h0};
      lfp_pkg::SHORT_CH_LO_OFS: read_reg = {1'b1, rb ? short_chan[31:0] : 32'h0};
      lfp_pkg::SHORT_CH_HI_OFS: read_reg = {1'b1, 16'h0, rb ? short_chan[47:32] : 16'h0};
      lfp_pkg::OPEN_LINE_LO_OFS: read_reg = {1'b1, rb ? open_line_log[31:0] : 32'h0};
      lfp_pkg::OPEN_LINE_HI_OFS: read_reg = {1'b1, rb ? open_line_log[63:32] : 32'h0};
      lfp_pkg::SHORT_LINE_LO_OFS: read_reg = {1'b1, rb ? short_line_log[31:0] : 32'h0};
      lfp_pkg::SHORT_LINE_HI_OFS: read_reg = {1'b1, rb ? short_line_log[63:32] : 32'h0};
      default: read_reg = {1'b0, 32'h0};
    endcase
  endfunction

  function automatic logic writable(input logic [7:0] a);
    writable = (a == lfp_pkg::CTRL_OFS) || (a == lfp_pkg::THRESH_OFS) ||
               (a == lfp_pkg::IRQ_STATUS_OFS) || (a == lfp_pkg::IRQ_MASK_OFS);
  endfunction

  // Address and data are held until both have arrived; one write at a time
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid && writable(wr_addr);
  logic wr_done;
  assign wr_done = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lfp_pkg::RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        // Partial strobes: lanes not enabled write zero
        for (int b = 0; b < 4; b++) begin
          wr_data[8*b +: 8] <= s_axi_wstrb[b] ? s_axi_wdata[8*b +: 8] : 8'h00;
        end
      end
      if (wr_done) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= writable(wr_addr) ? lfp_pkg::RESP_OKAY : lfp_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read answers one cycle after the address is taken
  logic [32:0] rd_word;
  always_comb rd_word = read_reg({s_axi_araddr[7:2], 2'b00});
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= lfp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word[31:0];
        s_axi_rresp <= rd_word[32] ? lfp_pkg::RESP_OKAY : lfp_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog settings
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (rst_regs) begin
      threshold_codes <= '0;
      short_ghost_removal_setting <= '0;
    end else begin
      threshold_codes <= thresh;
      short_ghost_removal_setting <= ctrl[lfp_pkg::CTRL_SHORT_RM_LSB +: lfp_pkg::SHORT_RM_W];
    end
  end
endmodule

//--- test/lfp_fault_protect_checker.sv
// Port-level assertions for the LED fault and protection block
`timescale 1ns/1ps
module lfp_fault_protect_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic ref_below_low,
  input wire logic temp_above_hot,
  input wire logic supply_undervoltage,
  input wire logic [47:0] channel_on,
  input wire logic frame_sync,
  input wire logic next_frame_all_zero,
  input wire logic next_frame_nonzero,
  input wire logic [47:0] channel_output,
  input wire logic [23:0] threshold_codes,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Protection modes
  // ----------------------------------------------------------------
  // Pins pass a two-flop sync, so allow six cycles before the outputs must be dark
  property p_ref_off;
    ref_below_low [*6] |-> channel_output == 48'h0;
  endproperty
  a_ref_off: assert property (p_ref_off)
    else $error("reference short left channels on");
  property p_hot_off;
    temp_above_hot [*6] |-> channel_output == 48'h0;
  endproperty
  a_hot_off: assert property (p_hot_off)
    else $error("thermal shutdown left channels on");
  property p_save_off;
    frame_sync && next_frame_all_zero && !next_frame_nonzero ##1 !next_frame_nonzero [*6]
      |-> channel_output == 48'h0;
  endproperty
  a_save_off: assert property (p_save_off)
    else $error("power saving left channels on");
  // A channel may only be lit if its PWM asked for it a cycle earlier
  property p_no_extra;
    (channel_output & ~$past(channel_on)) == 48'h0;
  endproperty
  a_no_extra: assert property (p_no_extra)
    else $error("channel lit without an on request");
  property p_uv_clear;
    supply_undervoltage [*7] |-> threshold_codes == 24'h0 && !irq;
  endproperty
  a_uv_clear: assert property (p_uv_clear)
    else $error("undervoltage did not clear registers");
  // ----------------------------------------------------------------
  // Register bus handshake
  // ----------------------------------------------------------------
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time)
    else $error("write response late");
  property p_w_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_busy: assert property (p_w_busy)
    else $error("write accepted while response pending");
  property p_r_time;
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_r_time: assert property (p_r_time)
    else $error("read data late");
  property p_r_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_busy: assert property (p_r_busy)
    else $error("read accepted while data pending");
endmodule

bind lfp_fault_protect lfp_fault_protect_checker lfp_fault_protect_checker_inst (.*);

//--- test/lfp_panel_model.sv
// Behavioural LED matrix with injectable open and shorted LEDs on one scan line
`timescale 1ns/1ps
module lfp_panel_model (
  input wire logic aclk,
  input wire logic [47:0] channel_on,
  input wire logic [5:0] scan_line,
  input wire logic [5:0] fault_line,
  input wire logic [47:0] open_leds,
  input wire logic [47:0] short_leds,
  output logic [47:0] open_cmp,
  output logic [47:0] short_cmp
);
  logic [47:0] noise = 48'hA5A5_0F0F_3C3C;
  logic hit;
  // An undriven output floats, so its comparators follow a noise pattern that changes every cycle
  always_ff @(posedge aclk) begin
    noise <= ~{noise[46:0], noise[47]};
  end
  // Open LED pulls the pin high, short LED pulls it low, only while lit
  assign hit = scan_line == fault_line;
  assign open_cmp = (channel_on & (hit ? open_leds : 48'h0)) | (~channel_on & noise);
  assign short_cmp = (channel_on & (hit ? short_leds : 48'h0)) | (~channel_on & ~noise);
endmodule

//--- test/lfp_fault_protect_bench.sv
// Self-checking bench for the LED fault and protection block
`timescale 1ns/1ps
module lfp_fault_protect_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, short_ghost_removal_setting;
  logic [31:0] s_axi_rdata;
  logic [47:0] open_cmp, short_cmp, channel_output;
  logic [23:0] threshold_codes;
  logic ref_below_low = 1'b0, ref_above_high = 1'b1;
  logic temp_above_hot = 1'b0, temp_below_cool = 1'b1, supply_undervoltage = 1'b0;
  logic [47:0] channel_on = 48'h0, open_leds = 48'h0, short_leds = 48'h0;
  logic [5:0] scan_line = 6'h00, fault_line = 6'h00;
  logic segment_end = 1'b0, frame_sync = 1'b0;
  logic next_frame_all_zero = 1'b0, next_frame_nonzero = 1'b0;
  logic [31:0] seed = 32'h2B;
  logic [33:0] rq[$];
  logic [5:0] lines[4] = '{6'h05, 6'h09, 6'h14, 6'h21};
  logic [47:0] eo[4];
  logic [47:0] on, om, sm;
  logic [63:0] lmap = 64'h0;
  logic [31:0] t;
  int miscompares = 0;
  int num_checks = 0;

  lfp_fault_protect lfp_fault_protect_inst (.*);
  lfp_panel_model lfp_panel_model_inst (.aclk(aclk), .channel_on(channel_on),
    .scan_line(scan_line), .fault_line(fault_line), .open_leds(open_leds),
    .short_leds(short_leds), .open_cmp(open_cmp), .short_cmp(short_cmp));

  always #5 aclk = ~aclk;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [47:0] r48();
    logic [31:0] a;
    a = rnd();
    return {a[15:0], rnd()};
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Bus master holds each channel until its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = lfp_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  // Expected read result is queued; the monitor below compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = lfp_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rq.push_back({er, d});
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end
  // One scan segment with the given lit channels and faulty LEDs
  task automatic seg(input logic [5:0] ln, input logic [47:0] c, input logic [47:0] o,
                     input logic [47:0] s);
    @(posedge aclk);
    {scan_line, fault_line} <= {ln, ln};
    {channel_on, open_leds, short_leds} <= {c, o, s};
    cyc(8);
    segment_end <= 1'b1;
    @(posedge aclk);
    segment_end <= 1'b0;
    channel_on <= 48'h0;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(lfp_pkg::CTRL_OFS, 32'h0);
    rd(lfp_pkg::STATUS_OFS, 32'h40);
    rd(8'h40, 32'h0, lfp_pkg::RESP_SLVERR);
    wr(lfp_pkg::STATUS_OFS, 32'hFF, lfp_pkg::RESP_SLVERR);
    t = rnd() & 32'h00FF_FFFF;
    wr(lfp_pkg::THRESH_OFS, t);
    wr(lfp_pkg::CTRL_OFS, 32'hB);
    cyc(2);
    chk(threshold_codes, t[23:0]);
    chk(short_ghost_removal_setting, 2'h2);
    rd(lfp_pkg::THRESH_OFS, t);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      on = r48() | 48'h1;
      om = r48() | 48'h1;
      sm = r48() | 48'h1;
      eo[i] = om & on;
      lmap[lines[i]] = 1'b1;
      seg(lines[i], on, om, sm);
      cyc(10);
      rd(lfp_pkg::OPEN_CH_LO_OFS, eo[i][31:0]);
      rd(lfp_pkg::OPEN_CH_HI_OFS, {16'h0, eo[i][47:32]});
      sm = sm & on;
      rd(lfp_pkg::SHORT_CH_LO_OFS, sm[31:0]);
      rd(lfp_pkg::SHORT_CH_HI_OFS, {16'h0, sm[47:32]});
    end
    rd(lfp_pkg::OPEN_LINE_LO_OFS, lmap[31:0]);
    rd(lfp_pkg::SHORT_LINE_HI_OFS, lmap[63:32]);
    $display("test fault capture done");
    @(posedge aclk);
    channel_on <= 48'hFFFF_FFFF_FFFF;
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      scan_line <= lines[i];
      cyc(3);
      chk(channel_output, i < 3 ? ~eo[i] : 48'hFFFF_FFFF_FFFF);
    end
    wr(lfp_pkg::CTRL_OFS, 32'h2);
    scan_line <= lines[0];
    cyc(3);
    chk(channel_output, 48'hFFFF_FFFF_FFFF);
    wr(lfp_pkg::CTRL_OFS, 32'h0);
    rd(lfp_pkg::OPEN_CH_LO_OFS, 32'h0);
    $display("test ghost removal done");
    rd(lfp_pkg::IRQ_STATUS_OFS, 32'h3);
    chk(irq, 1'b0);
    wr(lfp_pkg::IRQ_MASK_OFS, 32'h1F);
    cyc(2);
    chk(irq, 1'b1);
    wr(lfp_pkg::IRQ_STATUS_OFS, 32'h3);
    cyc(2);
    chk(irq, 1'b0);
    $display("test interrupt done");
    for (int k = 0; k < 3; k++) begin
      @(posedge aclk);
      case (k)
        0: {ref_below_low, ref_above_high} <= 2'b10;
        1: {temp_above_hot, temp_below_cool} <= 2'b10;
        default: {next_frame_all_zero, frame_sync} <= 2'b11;
      endcase
      @(posedge aclk);
      {next_frame_all_zero, frame_sync} <= 2'b00;
      cyc(6);
      chk(channel_output, 48'h0);
      rd(lfp_pkg::STATUS_OFS, k == 0 ? 32'h22 : k == 1 ? 32'h14 : 32'h31);
      @(posedge aclk);
      case (k)
        0: {ref_below_low, ref_above_high} <= 2'b01;
        1: {temp_above_hot, temp_below_cool} <= 2'b01;
        default: next_frame_nonzero <= 1'b1;
      endcase
      @(posedge aclk);
      next_frame_nonzero <= 1'b0;
      cyc(k == 2 ? 2 : 6);
      chk(channel_output, 48'hFFFF_FFFF_FFFF);
    end
    rd(lfp_pkg::IRQ_STATUS_OFS, 32'h1C);
    chk(irq, 1'b1);
    $display("test protection modes done");
    supply_undervoltage <= 1'b1;
    cyc(8);
    chk(threshold_codes, 24'h0);
    rd(lfp_pkg::IRQ_MASK_OFS, 32'h0);
    rd(lfp_pkg::STATUS_OFS, 32'h08);
    supply_undervoltage <= 1'b0;
    cyc(6);
    rd(lfp_pkg::STATUS_OFS, 32'h40);
    $display("test undervoltage done");
    end_of_test();
  end
endmodule
